// File: verilog/recx_ctrl.v
// external control inputs of the recorder: run/stop, chart clock, marker, sampling clock, triggers
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "recx_map.vh"

module recx_ctrl (
    input wire clock_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire run_in_i,
    input wire chart_clk_i,
    input wire marker_i,
    input wire samp_clk_i,
    input wire trig_in_i,
    input wire [31:0] values_i,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg rec_run_o,
    output reg mem_run_o,
    output reg sample_o,
    output reg marker_print_o,
    output reg msg_print_o,
    output reg [7:0] msg_num_o,
    output reg snap_print_o,
    output reg trig_out_o
);

    ////////////////////////////////////////////////////////////////////////////
    reg [31:0] ctrl_reg;
    reg [31:0] snap_reg;
    reg [31:0] speed_reg;
    reg [31:0] scnt_reg;
    reg [31:0] pcnt_reg;
    reg [31:0] win_reg;
    reg rec_panel_reg;
    reg mem_panel_reg;
    reg mem_done_reg;
    reg aw_have_reg;
    reg w_have_reg;
    reg [11:0] aw_reg;
    reg [31:0] wd_reg;
    reg [1:0] wstrb_reg;
    reg [31:0] rd_next;
    reg [1:0] rr_next;
    reg [4:0] s1_reg;
    reg [4:0] s2_reg;
    reg [4:0] s3_reg;
    reg [11:0] tdly_reg;
    reg tdly_run_reg;
    reg [8:0] tw_reg;
    reg samp_arm_reg;
    // load values kept 32 bits wide, cut to the counter widths where used
    localparam [31:0] TDLY_LOAD = `RECX_TDLY_CYC - 1;
    localparam [31:0] TOUT_LOAD = `RECX_TOUT_CYC - 1;
    wire [2:0] fsel = ctrl_reg[`RECX_FSEL_LSB +: `RECX_FSEL_W];
    wire [4:0] rise = s2_reg & ~s3_reg;
    wire [4:0] fall = ~s2_reg & s3_reg;
    wire [4:0] chg = s2_reg ^ s3_reg;
    wire busy = rec_run_o | mem_run_o;
    wire run_ena = fsel == `RECX_FN_REC || fsel == `RECX_FN_BOTH;
    wire mem_ena = fsel == `RECX_FN_MEM || fsel == `RECX_FN_BOTH;
    wire ext_samp = ctrl_reg[`RECX_EXTS_BIT];
    wire trig_edge = ctrl_reg[`RECX_TEDGE_BIT] ? fall[4] : rise[4];
    wire wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire cmd_wr = wr_fire && aw_reg == `RECX_CMD_OFS;
    wire key_rec = cmd_wr & wd_reg[`RECX_CMD_REC_BIT];
    wire key_mem = cmd_wr & wd_reg[`RECX_CMD_MEM_BIT];
    wire int_trig = cmd_wr & wd_reg[`RECX_CMD_TRIG_BIT];
    wire ext_trig = trig_edge & ~busy;
    wire samp_tick = ext_samp & rise[3] & mem_run_o;
    wire any_trig = int_trig | ext_trig;
    wire tout_go = tdly_run_reg & (rec_run_o ? tdly_reg == 12'h000 : samp_tick | ~ext_samp);

    ////////////////////////////////////////////////////////////////////////////
    // two-flop sync plus one delay stage for edges; first stage feeds only second
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= 5'h00;
            s2_reg <= 5'h00;
            s3_reg <= 5'h00;
        end else if (ce_i) begin
            s1_reg <= {trig_in_i, samp_clk_i, marker_i, chart_clk_i, run_in_i};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave, one answer per address, single outstanding read; a second write can be taken while a response waits
    always @* begin
        rd_next = 32'h00000000;
        rr_next = 2'h0;
        if (s_axi_araddr == `RECX_CTRL_OFS) begin
            rd_next = ctrl_reg;
        end else if (s_axi_araddr == `RECX_CMD_OFS) begin
            rd_next = 32'h00000000;
        end else if (s_axi_araddr == `RECX_STAT_OFS) begin
            rd_next = {27'h0000000, mem_done_reg, mem_panel_reg, rec_panel_reg, mem_run_o, rec_run_o};
        end else if (s_axi_araddr == `RECX_MSG_OFS) begin
            rd_next = {24'h000000, msg_num_o};
        end else if (s_axi_araddr == `RECX_SNAP_OFS) begin
            rd_next = snap_reg;
        end else if (s_axi_araddr == `RECX_SPEED_OFS) begin
            rd_next = speed_reg;
        end else if (s_axi_araddr == `RECX_SCNT_OFS) begin
            rd_next = scnt_reg;
        end else begin
            rr_next = 2'h2;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_reg <= 12'h000;
            wd_reg <= 32'h00000000;
            wstrb_reg <= 2'h0;
            ctrl_reg <= `RECX_CTRL_RST;
        end else if (ce_i) begin
            s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_reg <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_reg <= 1'b1;
                wd_reg <= s_axi_wdata;
                // strobes travel with the data; the master may move on before the write fires
                wstrb_reg <= s_axi_wstrb[1:0];
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_reg == `RECX_CTRL_OFS || aw_reg == `RECX_CMD_OFS) ? 2'h0 : 2'h2;
                if (aw_reg == `RECX_CTRL_OFS && wstrb_reg[0]) begin
                    ctrl_reg[7:0] <= wd_reg[7:0];
                end
                if (aw_reg == `RECX_CTRL_OFS && wstrb_reg[1]) begin
                    ctrl_reg[15:8] <= wd_reg[15:8];
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_next;
                s_axi_rresp <= rr_next;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run control: panel keys toggle, external input starts/stops
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rec_run_o <= 1'b0;
            mem_run_o <= 1'b0;
            rec_panel_reg <= 1'b0;
            mem_panel_reg <= 1'b0;
            mem_done_reg <= 1'b0;
            msg_print_o <= 1'b0;
            msg_num_o <= 8'h00;
            snap_print_o <= 1'b0;
            snap_reg <= 32'h00000000;
            marker_print_o <= 1'b0;
        end else if (ce_i) begin
            msg_print_o <= 1'b0;
            snap_print_o <= 1'b0;
            marker_print_o <= ctrl_reg[`RECX_MKEV_BIT] & ctrl_reg[`RECX_ANA_BIT] &
                ~ctrl_reg[`RECX_XY_BIT] & rise[1];
            if (key_rec) begin
                rec_run_o <= ~rec_run_o;
                rec_panel_reg <= ~rec_run_o;
            end else if (run_ena & rise[0] & ~rec_panel_reg) begin
                rec_run_o <= 1'b1;
            end else if (run_ena & fall[0]) begin
                rec_run_o <= 1'b0;
                rec_panel_reg <= 1'b0;
            end else if (ext_trig) begin
                rec_run_o <= ~ctrl_reg[`RECX_TACT_BIT];
            end
            if (key_mem) begin
                mem_run_o <= ~mem_run_o;
                mem_panel_reg <= ~mem_run_o;
                // completion in the same cycle as the key still counts
                mem_done_reg <= mem_run_o & ctrl_reg[`RECX_MEMDONE_BIT];
            end else if (mem_ena & rise[0] & ~mem_panel_reg) begin
                mem_run_o <= 1'b1;
                mem_done_reg <= 1'b0;
            end else if (mem_ena & fall[0] & ~mem_done_reg) begin
                mem_run_o <= 1'b0;
                mem_panel_reg <= 1'b0;
            end else if (mem_run_o & ctrl_reg[`RECX_MEMDONE_BIT]) begin
                mem_run_o <= 1'b0;
                mem_done_reg <= 1'b1;
            end else if (ext_trig) begin
                mem_run_o <= ctrl_reg[`RECX_TACT_BIT];
            end
            if (fsel == `RECX_FN_MSG && rise[0]) begin
                msg_print_o <= 1'b1;
                msg_num_o <= msg_num_o + 8'h01;
            end
            if (fsel == `RECX_FN_SNAP && chg[0]) begin
                snap_print_o <= 1'b1;
                snap_reg <= values_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // marker input frequency over a 1 s window, speed = f / 32; sample counter
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pcnt_reg <= 32'h00000000;
            win_reg <= 32'h00000000;
            speed_reg <= 32'h00000000;
            scnt_reg <= 32'h00000000;
            sample_o <= 1'b0;
            samp_arm_reg <= 1'b0;
        end else if (ce_i) begin
            sample_o <= samp_tick;
            samp_arm_reg <= samp_tick;
            if (samp_tick) begin
                scnt_reg <= scnt_reg + 32'h00000001;
            end else if (key_mem | (mem_ena & rise[0] & ~busy)) begin
                scnt_reg <= 32'h00000000;
            end
            if (win_reg == `RECX_WIN_CYC - 1) begin
                win_reg <= 32'h00000000;
                pcnt_reg <= 32'h00000000;
                if (ctrl_reg[`RECX_CHEXT_BIT]) begin
                    speed_reg <= pcnt_reg / `RECX_SPEED_DIV;
                end
            end else begin
                win_reg <= win_reg + 32'h00000001;
                if (rise[2]) begin
                    pcnt_reg <= pcnt_reg + 32'h00000001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger out: delay from internal trigger while recording, otherwise on the next sample tick or at once; then a stretched pulse
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tdly_reg <= 12'h000;
            tdly_run_reg <= 1'b0;
            tw_reg <= 9'h000;
            trig_out_o <= 1'b0;
        end else if (ce_i) begin
            if (int_trig & ~tdly_run_reg) begin
                tdly_run_reg <= 1'b1;
                tdly_reg <= TDLY_LOAD[11:0];
            end else if (tout_go) begin
                tdly_run_reg <= 1'b0;
            end else if (tdly_reg != 12'h000) begin
                tdly_reg <= tdly_reg - 12'h001;
            end
            if (tout_go) begin
                trig_out_o <= 1'b1;
                tw_reg <= TOUT_LOAD[8:0];
            end else if (tw_reg != 9'h000) begin
                tw_reg <= tw_reg - 9'h001;
            end else begin
                trig_out_o <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// File: include/recx_map.vh
// register offsets, field positions, reset values and timing counts for the external control block
`ifndef RECX_MAP_VH
`define RECX_MAP_VH
`define RECX_CLK_MHZ 125
`define RECX_CTRL_OFS 12'h000
`define RECX_CMD_OFS 12'h004
`define RECX_STAT_OFS 12'h008
`define RECX_MSG_OFS 12'h00C
`define RECX_SNAP_OFS 12'h010
`define RECX_SPEED_OFS 12'h014
`define RECX_SCNT_OFS 12'h018
`define RECX_FSEL_LSB 0
`define RECX_FSEL_W 3
`define RECX_CHEXT_BIT 3
`define RECX_MKEV_BIT 4
`define RECX_ANA_BIT 5
`define RECX_XY_BIT 6
`define RECX_EXTS_BIT 7
`define RECX_TEDGE_BIT 8
`define RECX_TACT_BIT 9
`define RECX_MEMDONE_BIT 10
`define RECX_CTRL_RST 32'h00000000
`define RECX_FN_REC 3'h0
`define RECX_FN_MEM 3'h1
`define RECX_FN_BOTH 3'h2
`define RECX_FN_MSG 3'h3
`define RECX_FN_SNAP 3'h4
`define RECX_CMD_REC_BIT 0
`define RECX_CMD_MEM_BIT 1
`define RECX_CMD_TRIG_BIT 2
`define RECX_TOUT_NS 2000
`define RECX_TOUT_CYC ((`RECX_TOUT_NS * `RECX_CLK_MHZ + 999) / 1000)
`define RECX_TDLY_NS 10000
`define RECX_TDLY_CYC ((`RECX_TDLY_NS * `RECX_CLK_MHZ) / 1000)
`define RECX_SPEED_DIV 32
`define RECX_WIN_CYC 125000000
`define RECX_MSG_FIRST 8'h01
`endif

// File: sim/recx_ctrl_properties.sv
// concurrent checks on the external control block's ports
`timescale 1ns/1ps
`default_nettype none
`include "recx_map.vh"
module recx_ctrl_props (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic marker_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic mem_run_o,
    input wire logic sample_o,
    input wire logic marker_print_o,
    input wire logic msg_print_o,
    input wire logic [7:0] msg_num_o,
    input wire logic snap_print_o,
    input wire logic trig_out_o
);
    logic [7:0] last_num;
    logic [8:0] hi_cnt;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    // high-time counter; 9 bits hold the 250-cycle pulse, but a trigger stuck high wraps it past 511
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_num <= 8'h00;
            hi_cnt <= 9'h000;
        end else begin
            hi_cnt <= trig_out_o ? hi_cnt + 9'h001 : 9'h000;
            if (msg_print_o) begin
                last_num <= msg_num_o;
            end
        end
    end
    ////////////////////////////////////////
    msg_order_a: assert property (msg_print_o |-> msg_num_o == last_num + 8'h01)
        else $error("message number not next in sequence");
    msg_once_a: assert property (msg_print_o |=> !msg_print_o)
        else $error("message pulse longer than one cycle");
    trig_width_a: assert property ($fell(trig_out_o) |-> hi_cnt == `RECX_TOUT_CYC)
        else $error("trigger out width wrong");
    trig_hold_a: assert property ($rose(trig_out_o) |-> trig_out_o [*8])
        else $error("trigger out pulse cut short");
    sample_gate_a: assert property (sample_o |-> mem_run_o || $past(mem_run_o))
        else $error("sample taken without capture");
    sample_once_a: assert property (sample_o |=> !sample_o)
        else $error("one clock pulse gave several samples");
    snap_once_a: assert property (snap_print_o |-> !$past(snap_print_o))
        else $error("snapshot repeated");
    marker_cause_a: assert property (marker_print_o |-> $past(marker_i, 3) && !$past(marker_print_o))
        else $error("marker print without marker edge");
    resp_hold_a: assert property (s_axi_bvalid && ce_i |=> s_axi_bvalid == !$past(s_axi_bready))
        else $error("write response not held until taken");
    addr_take_a: assert property (s_axi_awready |-> s_axi_awvalid)
        else $error("write address taken with no request");
endmodule
bind recx_ctrl recx_ctrl_props i_props (.clock_i, .rst_n_i, .ce_i, .marker_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .s_axi_bready, .mem_run_o, .sample_o, .marker_print_o, .msg_print_o, .msg_num_o,
    .snap_print_o, .trig_out_o);
`default_nettype wire

// File: sim/recx_ext_model.sv
// behavioural model of the equipment on the rear-panel side
`timescale 1ns/1ps
`default_nettype none
module recx_ext_model (
    input wire logic clock_i,
    output logic trig_o,
    output logic samp_o
);
    initial begin
        trig_o = 1'h0;
        samp_o = 1'h0;
    end
    ////////////////////////////////////////
    // sole driver on the trigger line, pulse held the whole width
    task automatic trig(input int w);
        trig_o <= 1'h1;
        repeat (w) @(posedge clock_i);
        trig_o <= 1'h0;
        repeat (8) @(posedge clock_i);
    endtask
    // 50 kHz, so it stays legal with recording alongside
    task automatic samp(input int n);
        repeat (n) begin
            samp_o <= 1'h1;
            repeat (1250) @(posedge clock_i);
            samp_o <= 1'h0;
            repeat (1250) @(posedge clock_i);
        end
    endtask
endmodule
`default_nettype wire

// File: sim/recorder_external_control_inputs_test.sv
// self-checking bench for the external control block
`timescale 1ns/1ps
`default_nettype none
`include "recx_map.vh"
`define CHK(a, e) \
    begin \
        compares++; \
        if ((a) !== (e)) begin \
            err_count++; \
            $display("unexpected at %0t: got %h want %h", $time, a, e); \
        end \
    end
module recorder_external_control_inputs_test;
    localparam logic [11:0] CTRL = `RECX_CTRL_OFS;
    localparam logic [11:0] CMD = `RECX_CMD_OFS;
    localparam logic [11:0] STAT = `RECX_STAT_OFS;
    localparam logic [31:0] TACT = 32'h1 << `RECX_TACT_BIT;
    localparam logic [31:0] MKAN = (32'h1 << `RECX_MKEV_BIT) | (32'h1 << `RECX_ANA_BIT);
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic run_in = 1'h0, mk = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic [11:0] aw = 12'h000, ar = 12'h000;
    logic [31:0] wd = 32'h0, vals = 32'h0;
    logic [7:0] msg_last = 8'h00;
    logic [3:0] strb = 4'hF;
    logic ce = 1'h1, chart = 1'h0;
    wire logic awr, wrdy, bv, arr, rv, trig, samp, rec_o, mem_o, smp, mkp, msgp, snp, tro;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] mnum;
    int err_count = 0, compares = 0, msg_cnt = 0, snap_cnt = 0, mark_cnt = 0, samp_cnt = 0, n;
    always #4 clock_i = ~clock_i;
    recx_ctrl i_dut (.clock_i, .rst_n_i, .ce_i(ce), .run_in_i(run_in), .chart_clk_i(chart), .marker_i(mk),
        .samp_clk_i(samp), .trig_in_i(trig), .values_i(vals), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .rec_run_o(rec_o), .mem_run_o(mem_o), .sample_o(smp), .marker_print_o(mkp), .msg_print_o(msgp),
        .msg_num_o(mnum), .snap_print_o(snp), .trig_out_o(tro));
    recx_ext_model i_ext (.clock_i, .trig_o(trig), .samp_o(samp));
    ////////////////////////////////////////
    always @(posedge clock_i) begin
        if (msgp === 1'h1) begin
            msg_cnt++;
            msg_last = mnum;
        end
        if (snp === 1'h1) snap_cnt++;
        if (mkp === 1'h1) mark_cnt++;
        if (smp === 1'h1) samp_cnt++;
    end
    // bready offered with the request; response taken at the handshake edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        aw <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        do begin
            @(posedge clock_i);
            if (awr) awv <= 1'h0;
            if (wrdy) wv <= 1'h0;
        end while (!bv);
        bry <= 1'h0;
        `CHK(bresp, r)
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        ar <= a;
        arv <= 1'h1;
        rry <= 1'h1;
        do begin
            @(posedge clock_i);
            if (arr) arv <= 1'h0;
        end while (!rv);
        rry <= 1'h0;
        `CHK(rdata, d)
        `CHK(rresp, r)
        @(posedge clock_i);
    endtask
    // sync plus edge detect plus one register
    task automatic run(input logic v);
        run_in <= v;
        repeat (6) @(posedge clock_i);
    endtask
    task automatic mark();
        mk <= 1'h1;
        chart <= 1'h1;
        repeat (6) @(posedge clock_i);
        mk <= 1'h0;
        chart <= 1'h0;
        repeat (6) @(posedge clock_i);
    endtask
    task automatic results();
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #480000;
        err_count++;
        results();
    end
    initial begin
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'h1;
        @(posedge clock_i);
        rd(CTRL, `RECX_CTRL_RST, 2'h0);
        rd(12'h020, 32'h0, 2'h2);
        wr(STAT, 32'h1, 2'h2);
        strb <= 4'h2;
        wr(CTRL, 32'h00000304, 2'h0);
        strb <= 4'hF;
        rd(CTRL, 32'h00000300, 2'h0);
        for (int f = 0; f < 3; f++) begin
            wr(CTRL, f, 2'h0);
            run(1'h1);
            `CHK({rec_o, mem_o}, {f != 1, f != 0})
            run(1'h0);
            `CHK({rec_o, mem_o}, 2'h0)
        end
        wr(CTRL, `RECX_FN_MSG, 2'h0);
        for (int i = 1; i < 4; i++) begin
            run(1'h1);
            `CHK(msg_last, 8'(i))
            run(1'h0);
        end
        `CHK(msg_cnt, 3)
        ce <= 1'h0;
        run(1'h1);
        `CHK(msg_cnt, 3)
        ce <= 1'h1;
        repeat (6) @(posedge clock_i);
        `CHK(msg_last, 8'h04)
        run(1'h0);
        wr(CTRL, `RECX_FN_SNAP, 2'h0);
        vals <= 32'h5A5AC3C3;
        run(1'h1);
        vals <= 32'h0F0F1234;
        rd(`RECX_SNAP_OFS, 32'h5A5AC3C3, 2'h0);
        run(1'h0);
        rd(`RECX_SNAP_OFS, 32'h0F0F1234, 2'h0);
        `CHK(snap_cnt, 2)
        wr(CTRL, `RECX_FN_REC, 2'h0);
        run(1'h1);
        rd(STAT, 32'h1, 2'h0);
        wr(CMD, 32'h1, 2'h0);
        rd(STAT, 32'h0, 2'h0);
        run(1'h0);
        wr(CMD, 32'h1, 2'h0);
        run(1'h1);
        rd(STAT, 32'h5, 2'h0);
        wr(CMD, 32'h4, 2'h0);
        n = 0;
        while (tro !== 1'h1) begin
            @(posedge clock_i);
            n++;
        end
        `CHK(n inside {[1240:1256]}, 1'h1)
        repeat (260) @(posedge clock_i);
        `CHK(tro, 1'h0)
        wr(CTRL, TACT, 2'h0);
        i_ext.trig(250);
        `CHK(mem_o, 1'h0)
        wr(CMD, 32'h1, 2'h0);
        run(1'h0);
        wr(CTRL, 32'h0, 2'h0);
        i_ext.trig(250);
        `CHK(rec_o, 1'h1)
        wr(CMD, 32'h1, 2'h0);
        wr(CTRL, TACT | (32'h1 << `RECX_TEDGE_BIT), 2'h0);
        fork
            i_ext.trig(250);
        join_none
        repeat (100) @(posedge clock_i);
        `CHK(mem_o, 1'h0)
        wait fork;
        `CHK(mem_o, 1'h1)
        wr(CMD, 32'h2, 2'h0);
        wr(CTRL, MKAN, 2'h0);
        mark();
        wr(CTRL, MKAN | (32'h1 << `RECX_XY_BIT), 2'h0);
        mark();
        `CHK(mark_cnt, 1)
        rd(`RECX_SPEED_OFS, 32'h0, 2'h0);
        wr(CTRL, `RECX_FN_MEM | (32'h1 << `RECX_EXTS_BIT), 2'h0);
        i_ext.samp(1);
        wr(CMD, 32'h2, 2'h0);
        i_ext.samp(3);
        `CHK(samp_cnt, 3)
        rd(`RECX_SCNT_OFS, 32'h3, 2'h0);
        results();
    end
endmodule
`default_nettype wire
